/* File: asw_status.sv */
// extended status word assembly with an Avalon-MM register slave
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`include "asw_map.svh"
`default_nettype none
module asw_status
  import asw_pkg::*;
#(
  parameter int SEC_CYCLES = `ASW_SEC_CYCLES
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire asw_event_type events,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [31:0] status_word
);
  // ****************************************
  // one second tick
  // ****************************************
  logic [31:0] tick_cnt; // cycles within the current second
  logic [31:0] next_tick_cnt;
  logic sec_tick; // one-cycle enable each second
  always_comb
  begin
    sec_tick = (tick_cnt == SEC_CYCLES - 1);
    next_tick_cnt = sec_tick ? 32'h00000000 : tick_cnt + 32'h00000001;
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      tick_cnt <= 32'h00000000;
    else
      tick_cnt <= next_tick_cnt;
  end
  // ****************************************
  // fault timers and restart flag
  // ****************************************
  logic [15:0] avg_time; // averaging time in seconds, software set
  logic [15:0] buf_depth; // buffer capacity in values, software set
  logic [7:0] gap_sec; // seconds since last new sample
  logic [7:0] next_gap_sec;
  logic [7:0] bad_sec; // seconds a fault has persisted
  logic [7:0] next_bad_sec;
  logic restart; // set by reset, cleared by first telegram
  logic next_restart;
  logic gen_fault;
  logic fault_now;
  logic [3:0] fill;
  always_comb
  begin
    next_gap_sec = gap_sec;
    if (events.new_sample)
      next_gap_sec = 8'h00;
    else if (sec_tick && gap_sec != 8'hFF)
      next_gap_sec = gap_sec + 8'h01;
    if (avg_time < `ASW_SHORT_AVG_SEC)
      gen_fault = (gap_sec >= 8'(`ASW_GAP_SEC));
    else
      gen_fault = ({events.buf_count, 1'b0} < {1'b0, avg_time});
    // a persistent fault is a temperature limit violation or absent samples
    fault_now = events.virtual_temperature_limit || (gap_sec >= 8'(`ASW_GAP_SEC));
    next_bad_sec = bad_sec;
    if (!fault_now)
      next_bad_sec = 8'h00;
    else if (sec_tick && bad_sec != 8'hFF)
      next_bad_sec = bad_sec + 8'h01;
    next_restart = restart;
    if (events.telegram_sent)
      next_restart = 1'b0;
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      gap_sec <= 8'h00;
      bad_sec <= 8'h00;
      restart <= 1'b1;
    end
    else
    begin
      gap_sec <= next_gap_sec;
      bad_sec <= next_bad_sec;
      restart <= next_restart;
    end
  end
  // fill level in sixteenths of the configured depth
  asw_fill_level i_asw_fill_level
  (
    .count(events.buf_count),
    .depth(buf_depth),
    .level(fill)
  );
  // ****************************************
  // status word register
  // ****************************************
  logic [31:0] next_status_word;
  always_comb
  begin
    next_status_word = 32'h00000000;
    next_status_word[`ASW_BIT_GEN_FAULT] = gen_fault;
    next_status_word[`ASW_BIT_HEAT_CRIT] = events.heat_criterion;
    next_status_word[`ASW_BIT_HEAT_ON] = events.heat_on;
    // strictly more than one minute
    next_status_word[`ASW_BIT_STATIC_FAULT] = (bad_sec > 8'(`ASW_STATIC_SEC));
    next_status_word[`ASW_FILL_LSB +: 4] = fill;
    next_status_word[`ASW_BIT_RESTART] = next_restart;
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      status_word <= `ASW_STATUS_RESET;
    else
      status_word <= next_status_word;
  end
  // ****************************************
  // Avalon-MM slave, one wait state per access
  // ****************************************
  asw_bus_state_type bus_state;
  asw_bus_state_type next_bus_state;
  logic [31:0] next_readdata;
  logic [15:0] next_avg_time;
  logic [15:0] next_buf_depth;
  always_comb
  begin
    next_bus_state = bus_state;
    next_readdata = readdata;
    next_avg_time = avg_time;
    next_buf_depth = buf_depth;
    waitrequest = (read || write) && (bus_state != ASW_DONE);
    case (bus_state)
      ASW_IDLE:
      begin
        if (read || write)
          next_bus_state = ASW_DONE;
        if (read)
        begin
          if (address == `ASW_ADDR_STATUS)
            next_readdata = status_word;
          else if (address == `ASW_ADDR_AVG_TIME)
            next_readdata = {16'h0000, avg_time};
          else if (address == `ASW_ADDR_FILL)
            next_readdata = {16'h0000, buf_depth};
          else
            next_readdata = 32'h00000000; // unmapped reads zero
        end
      end
      ASW_DONE:
      begin
        next_bus_state = ASW_IDLE;
        if (write)
        begin
          if (address == `ASW_ADDR_AVG_TIME)
            next_avg_time = writedata[15:0];
          else if (address == `ASW_ADDR_FILL)
            next_buf_depth = writedata[15:0];
        end
      end
      default:
        next_bus_state = ASW_IDLE;
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      bus_state <= ASW_IDLE;
      readdata <= 32'h00000000;
      avg_time <= `ASW_AVG_TIME_RESET;
      buf_depth <= `ASW_BUF_DEPTH_RESET;
    end
    else
    begin
      bus_state <= next_bus_state;
      readdata <= next_readdata;
      avg_time <= next_avg_time;
      buf_depth <= next_buf_depth;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  // the first edge after reset still shows the reset word, so skip it
  a_heat_crit_follow: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> status_word[1] == $past(events.heat_criterion))
    else $error("heat criterion bit wrong");
  a_heat_on_follow: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> status_word[2] == $past(events.heat_on))
    else $error("heater bit wrong");
  a_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
    (status_word & 32'hFFFFC0E8) == 32'h00000000) else $error("reserved bit set");
  a_bit12_zero: assert property (@(posedge clock) disable iff (sys_rst)
    !status_word[12]) else $error("bit 12 set");
  // a cleared restart flag stays low on the following update too
  sequence s_restart_low;
    !status_word[13] ##1 !status_word[13];
  endsequence
  a_restart_clear: assert property (@(posedge clock) disable iff (sys_rst)
    events.telegram_sent |=> s_restart_low) else $error("restart kept");
  a_restart_set: assert property (@(posedge clock)
    sys_rst |=> status_word[13]) else $error("restart not set");
  a_short_gap: assert property (@(posedge clock) disable iff (sys_rst)
    (avg_time < 16'h000A && gap_sec >= 8'h0A && !events.new_sample) |=> status_word[0])
    else $error("gap fault missing");
  a_long_half: assert property (@(posedge clock) disable iff (sys_rst)
    (avg_time >= 16'h000A && {events.buf_count, 1'b0} >= {1'b0, avg_time}) |=> !status_word[0])
    else $error("false half fault");
  a_static_time: assert property (@(posedge clock) disable iff (sys_rst)
    status_word[4] |-> $past(bad_sec) > 8'h3C) else $error("static fault early");
  a_fill_full: assert property (@(posedge clock) disable iff (sys_rst)
    (events.buf_count == buf_depth && buf_depth != 16'h0000) |=> status_word[11:8] == 4'hF)
    else $error("full level wrong");
endmodule
`default_nettype wire

/* File: asw_map.svh */
// constants for the anemometer status word block
`ifndef ASW_MAP_SVH
`define ASW_MAP_SVH
// ****************************************
// register map
// ****************************************
`define ASW_ADDR_STATUS 4'h0
`define ASW_ADDR_AVG_TIME 4'h4
`define ASW_ADDR_FILL 4'h8
`define ASW_AVG_TIME_RESET 16'h000A
`define ASW_BUF_DEPTH_RESET 16'h0010
`define ASW_STATUS_RESET 32'h00002000
// ****************************************
// field positions
// ****************************************
`define ASW_BIT_GEN_FAULT 0
`define ASW_BIT_HEAT_CRIT 1
`define ASW_BIT_HEAT_ON 2
`define ASW_BIT_STATIC_FAULT 4
`define ASW_FILL_LSB 8
`define ASW_BIT_RESTART 13
// ****************************************
// timing
// ****************************************
`define ASW_CLOCK_HZ 50000000
`define ASW_GAP_SEC 10
`define ASW_STATIC_SEC 60
`define ASW_SHORT_AVG_SEC 16'h000A
`define ASW_SEC_CYCLES (`ASW_CLOCK_HZ)
`endif

/* File: asw_pkg.sv */
// types for the anemometer status word block
`default_nettype none
package asw_pkg;
  // inputs from measurement, averaging, heating and telegram logic
  typedef struct packed {
    logic new_sample;
    logic heat_criterion;
    logic heat_on;
    logic virtual_temperature_limit;
    logic telegram_sent;
    logic [15:0] buf_count;
  } asw_event_type;
  // status of the Avalon slave
  typedef enum logic [1:0] {
    ASW_IDLE = 2'b01,
    ASW_DONE = 2'b10
  } asw_bus_state_type;
endpackage
`default_nettype wire

/* File: asw_fill_level.sv */
// fill level of the averaging buffer in sixteenths
`default_nettype none
module asw_fill_level
  import asw_pkg::*;
(
  input wire logic [15:0] count,
  input wire logic [15:0] depth,
  output logic [3:0] level
);
  // level n when n/16 < count/depth <= (n+1)/16; zero stays in slice 0
  logic [19:0] scaled;
  logic [19:0] num;
  always_comb
  begin
    num = {count, 4'h0};
    scaled = 20'h00000;
    if (count != 16'h0000 && depth != 16'h0000)
    begin
      scaled = (num - 20'h00001) / {4'h0, depth};
    end
    level = (scaled > 20'h0000F) ? 4'hF : scaled[3:0];
  end
endmodule
`default_nettype wire

/* File: test_anemometer_status_word.sv */
// self-checking testbench for the anemometer status word block
`default_nettype none
module test_anemometer_status_word
  import asw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clock = 1'b0; // 50 MHz system clock
  logic sys_rst = 1'b1; // held for 8 cycles at start
  asw_event_type events = '{default: 1'b0, buf_count: 16'h0010}; // full buffer keeps bit 0 low
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [31:0] status_word;
  logic [31:0] rd; // last read data
  logic sample_en = 1'b1; // enables background sample pulses
  logic sample_pulse = 1'b0; // background sample pulse, one driver only
  asw_event_type dut_events; // scenario fields plus the background pulse
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  // short second so the minute-long checks stay cheap
  asw_status #(.SEC_CYCLES(10)) i_asw_status (.clock(clock), .sys_rst(sys_rst),
    .events(dut_events), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .status_word(status_word));
  initial forever #10 clock = ~clock;
  // merge the pulse into the event word so no field has two drivers
  always_comb
  begin
    dut_events = events;
    dut_events.new_sample = sample_pulse;
  end
  // a sample every fourth cycle keeps the gap watch quiet; also the hang limit
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    sample_pulse <= sample_en && (cyc % 4 == 0);
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one edge for the inputs, one for the registered word, then look mid-cycle
  task automatic settle();
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask
  // avalon access: hold until waitrequest is sampled low at a rising edge,
  // take read data at that edge and release only then; the bench timeout ends a hang
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do
    begin
      @(posedge clock);
      n = n + 1;
    end
    while (waitrequest !== 1'b0);
    rd = readdata;
    chk("wait cycles", 32'h2, n); // one wait state per access
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_heat();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      events.heat_criterion <= i[0];
      events.heat_on <= i[1];
      settle();
      chk("heat criterion", {31'h0, i[0]}, {31'h0, status_word[1]});
      chk("heater on", {31'h0, i[1]}, {31'h0, status_word[2]});
    end
    @(posedge clock);
    events.heat_criterion <= 1'b0;
    events.heat_on <= 1'b0;
    $display("test heat done");
  endtask
  task automatic t_fill();
    int c;
    int cnt[8] = '{0, 1, 2, 4, 5, 8, 16, 17};
    for (int i = 0; i < 8; i++)
    begin
      c = cnt[i];
      @(posedge clock);
      events.buf_count <= c[15:0];
      settle();
      c = (c == 0) ? 0 : ((c > 16) ? 15 : c - 1);
      chk("fill level", c, {28'h0, status_word[11:8]});
      chk("low buffer", {31'h0, cnt[i] < 5}, {31'h0, status_word[0]});
      chk("reserved", 32'h0, status_word & 32'hFFFFD0E8);
    end
    @(posedge clock);
    events.buf_count <= 16'h0010;
    $display("test fill done");
  endtask
  task automatic t_short();
    av(1'b1, 4'h4, 32'h5);
    sample_en <= 1'b0;
    repeat (80) @(posedge clock);
    chk("gap early", 32'h0, {31'h0, status_word[0]});
    repeat (50) @(posedge clock);
    chk("gap flagged", 32'h1, {31'h0, status_word[0]});
    sample_en <= 1'b1;
    repeat (8) @(posedge clock);
    chk("gap cleared", 32'h0, {31'h0, status_word[0]});
    av(1'b1, 4'h4, 32'hA);
    $display("test short average done");
  endtask
  task automatic t_static();
    events.virtual_temperature_limit <= 1'b1;
    repeat (550) @(posedge clock);
    chk("static early", 32'h0, {31'h0, status_word[4]});
    repeat (170) @(posedge clock);
    chk("static set", 32'h1, {31'h0, status_word[4]});
    events.virtual_temperature_limit <= 1'b0;
    settle();
    chk("static clear", 32'h0, {31'h0, status_word[4]});
    $display("test static done");
  endtask
  task automatic t_restart();
    @(posedge clock);
    events.telegram_sent <= 1'b1;
    @(posedge clock);
    events.telegram_sent <= 1'b0;
    repeat (20) @(posedge clock);
    chk("restart cleared", 32'h0, {31'h0, status_word[13]});
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    chk("restart set", 32'h00002F00, status_word);
    $display("test restart done");
  endtask
  task automatic t_bus();
    av(1'b0, 4'h0, 32'h0);
    chk("status read", 32'h00002F00, rd);
    av(1'b1, 4'h0, 32'hFFFFFFFF);
    av(1'b0, 4'h0, 32'h0);
    chk("status read only", 32'h00002F00, rd);
    av(1'b0, 4'hC, 32'h0);
    chk("unmapped read", 32'h0, rd);
    av(1'b0, 4'h4, 32'h0);
    chk("average time", 32'hA, rd);
    av(1'b0, 4'h8, 32'h0);
    chk("buffer depth", 32'h10, rd);
    av(1'b1, 4'h8, 32'h8);
    av(1'b0, 4'h8, 32'h0);
    chk("depth written", 32'h8, rd);
    events.buf_count <= 16'h0003;
    settle();
    chk("fill of eight", 32'h5, {28'h0, status_word[11:8]});
    $display("test bus done");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clock);
    chk("reset word", 32'h00002000, status_word);
    sys_rst <= 1'b0;
    settle();
    chk("idle word", 32'h00002F00, status_word);
    $display("test reset done");
    t_heat();
    t_fill();
    t_short();
    t_static();
    t_restart();
    t_bus();
    print_verdict();
  end
endmodule
`default_nettype wire
